/* hdl/power_mode_irq_mask_control.v */
// Contract
// - Power-enable bit one powers section, zero off.
// - Reset leaves only power-enable bit 0 set.
// - Bit 0 powers clocks, processor, ports; keypad stays.
// - Bit 2 enables control-channel data reception.
// - Bit 3 enables dual-tone generator and receive.
// - Bit 4 enables speech, data, tone paths.
// - Decode low five bits into six modes.
// - Option bit 0 selects one or two busy bits.
// - Option bit 1 picks eleven or five repeats.
// - Option bit 2 low enables automatic muting.
// - Option bit 3 enables receiver idle saving.
// - Mask one enables seven event interrupts.
// - Mask two enables eight event interrupts.
// - Any commence write starts the precursor.
// - Precursor end takes buffer, raises buffer-available.
// - Polarity bit 3 selects interrupt pin level.
// - Tone status event interrupts only with mask 6.
`include "power_mode_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module power_mode_irq_mask_control #(
   parameter PRECURSOR_CYCLES = `PRECURSOR_CYCLES_DEFAULT
) (
   input wire clk,
   input wire rst,
   input wire spi_clk,
   input wire spi_select_n,
   input wire spi_data_in,
   input wire [`EVENT_MSB:0] event_pulse,
   input wire [`EVENT_MSB:0] flag_clear,
   input wire tx_data_word_write,
   output reg [`EVENT_MSB:0] event_flags_q,
   output reg interrupt_pin_q,
   output reg clock_power_q,
   output reg processor_power_q,
   output reg keypad_power_q,
   output reg control_rx_enable_q,
   output reg dual_tone_enable_q,
   output reg speech_tx_rx_enable_q,
   output reg [`MODE_WIDTH-1:0] power_mode_q,
   output reg two_busy_bits_q,
   output reg five_repeat_limit_q,
   output reg auto_mute_enable_q,
   output reg rx_idle_enable_q,
   output reg precursor_active_q,
   output reg buffer_take_q,
   output reg late_data_write_q
);

   // One-hot power modes; the last code flags a forbidden combination.
   localparam MODE_POWER_DOWN = 7'h01;
   localparam MODE_SHUTDOWN = 7'h02;
   localparam MODE_IDLE = 7'h04;
   localparam MODE_TONE = 7'h08;
   localparam MODE_FULL_TONE_OFF = 7'h10;
   localparam MODE_FULL_TONE_ON = 7'h20;
   localparam MODE_ILLEGAL = 7'h40;

   // One-hot precursor sequencer states.
   localparam TX_IDLE = 3'h1;
   localparam TX_PRECURSOR = 3'h2;
   localparam TX_TAKE = 3'h4;

   localparam [31:0] PRECURSOR_LAST_WIDE = PRECURSOR_CYCLES - 1;
   localparam [`PRECURSOR_COUNT_WIDTH-1:0] PRECURSOR_LAST = PRECURSOR_LAST_WIDE[`PRECURSOR_COUNT_WIDTH-1:0];

   reg [`POWER_ENABLE_WIDTH-1:0] power_enable_word_q;
   reg [`OPTIONAL_CONTROL_WIDTH-1:0] optional_control_word_q;
   reg [`IRQ_MASK_ONE_WIDTH-1:0] irq_mask_one_q;
   reg [`IRQ_MASK_TWO_WIDTH-1:0] irq_mask_two_q;
   reg [`POLARITY_WIDTH-1:0] polarity_word_q;

   reg spi_clk_prev_q;
   reg [`FRAME_COUNT_WIDTH-1:0] bit_count_q;
   reg [`FRAME_BITS-2:0] shift_q;
   reg write_valid_q;
   reg [`ADDR_WIDTH-1:0] write_addr_q;
   reg [`DATA_WIDTH-1:0] write_data_q;

   reg [2:0] tx_state_q;
   reg [2:0] tx_state_d;
   reg [`PRECURSOR_COUNT_WIDTH-1:0] precursor_count_q;

   wire [`SYNC_WIDTH-1:0] pins_sync;
   wire spi_clk_s;
   wire spi_select_n_s;
   wire spi_data_s;
   wire spi_rise;
   wire [`EVENT_MSB:0] event_set;
   wire [`EVENT_MSB:0] irq_mask_all;
   wire commence_write;

   // Decodes the low five power-enable bits into a one-hot mode.
   function [`MODE_WIDTH-1:0] decode_mode;
      input [`PE_MODE_MSB:0] code;
      begin
         case (code)
            `MODE_CODE_POWER_DOWN: decode_mode = MODE_POWER_DOWN;
            `MODE_CODE_SHUTDOWN: decode_mode = MODE_SHUTDOWN;
            `MODE_CODE_IDLE: decode_mode = MODE_IDLE;
            `MODE_CODE_TONE: decode_mode = MODE_TONE;
            `MODE_CODE_FULL_TONE_OFF: decode_mode = MODE_FULL_TONE_OFF;
            `MODE_CODE_FULL_TONE_ON: decode_mode = MODE_FULL_TONE_ON;
            default: decode_mode = MODE_ILLEGAL;
         endcase
      end
   endfunction

   // Address match for a completed serial write.
   function addr_hit;
      input valid;
      input [`ADDR_WIDTH-1:0] addr;
      input [`ADDR_WIDTH-1:0] target;
      begin
         addr_hit = valid & (addr == target);
      end
   endfunction

   pin_synchronizer #(
      .WIDTH(`SYNC_WIDTH)
   ) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .pin_async({spi_data_in, spi_select_n, spi_clk}),
      .reset_level(3'h2),
      .pin_sync_q(pins_sync)
   );

   assign spi_clk_s = pins_sync[0];
   assign spi_select_n_s = pins_sync[1];
   assign spi_data_s = pins_sync[2];
   assign spi_rise = spi_clk_s & ~spi_clk_prev_q;

   // Serial write port: select low, sixteen bits MSB first, sampled on the rising
   // edge of the serial clock. The serial clock must run well below clk/4 because
   // it is oversampled through the synchroniser.
   always @(posedge clk) begin
      if (rst) begin
         spi_clk_prev_q <= 1'b0;
         bit_count_q <= {`FRAME_COUNT_WIDTH{1'b0}};
         shift_q <= {(`FRAME_BITS-1){1'b0}};
         write_valid_q <= 1'b0;
         write_addr_q <= {`ADDR_WIDTH{1'b0}};
         write_data_q <= {`DATA_WIDTH{1'b0}};
      end else begin
         spi_clk_prev_q <= spi_clk_s;
         write_valid_q <= 1'b0;
         if (spi_select_n_s) begin
            // A frame cut short by deselect is dropped.
            bit_count_q <= {`FRAME_COUNT_WIDTH{1'b0}};
         end else if (spi_rise) begin
            if (bit_count_q == `FRAME_BITS - 5'd1) begin
               write_valid_q <= 1'b1;
               write_addr_q <= shift_q[`FRAME_BITS-2:`DATA_WIDTH-1];
               write_data_q <= {shift_q[`DATA_WIDTH-2:0], spi_data_s};
               bit_count_q <= {`FRAME_COUNT_WIDTH{1'b0}};
            end else begin
               shift_q <= {shift_q[`FRAME_BITS-3:0], spi_data_s};
               bit_count_q <= bit_count_q + 5'd1;
            end
         end
      end
   end

   // Control words. Reset leaves the part in shutdown mode.
   always @(posedge clk) begin
      if (rst) begin
         power_enable_word_q <= `POWER_ENABLE_RESET;
         optional_control_word_q <= `OPTIONAL_CONTROL_RESET;
         irq_mask_one_q <= `IRQ_MASK_ONE_RESET;
         irq_mask_two_q <= `IRQ_MASK_TWO_RESET;
         polarity_word_q <= `POLARITY_RESET;
      end else begin
         if (addr_hit(write_valid_q, write_addr_q, `ADDR_POWER_ENABLE_WORD)) begin
            // Unused bits 5 to 7 are not stored.
            power_enable_word_q <= {3'h0, write_data_q[`PE_MODE_MSB:0]};
         end
         if (addr_hit(write_valid_q, write_addr_q, `ADDR_OPTIONAL_CONTROL_WORD)) begin
            optional_control_word_q <= write_data_q[`OPTIONAL_CONTROL_WIDTH-1:0];
         end
         if (addr_hit(write_valid_q, write_addr_q, `ADDR_IRQ_MASK_ONE)) begin
            irq_mask_one_q <= write_data_q[`IRQ_MASK_ONE_WIDTH-1:0];
         end
         if (addr_hit(write_valid_q, write_addr_q, `ADDR_IRQ_MASK_TWO)) begin
            irq_mask_two_q <= write_data_q[`IRQ_MASK_TWO_WIDTH-1:0];
         end
         if (addr_hit(write_valid_q, write_addr_q, `ADDR_POLARITY_WORD)) begin
            polarity_word_q <= write_data_q[`POLARITY_WIDTH-1:0];
         end
      end
   end

   // Section enables. The security bit is trusted to be the inverse of the clock bit, so it
   // steers nothing; the mode decode reports a mismatch as illegal instead.
   always @(posedge clk) begin
      if (rst) begin
         clock_power_q <= 1'b0;
         processor_power_q <= 1'b0;
         keypad_power_q <= 1'b0;
         control_rx_enable_q <= 1'b0;
         dual_tone_enable_q <= 1'b0;
         speech_tx_rx_enable_q <= 1'b0;
         power_mode_q <= MODE_SHUTDOWN;
      end else begin
         clock_power_q <= power_enable_word_q[`PE_CLOCK_BIT];
         processor_power_q <= power_enable_word_q[`PE_CLOCK_BIT];
         keypad_power_q <= 1'b1;
         control_rx_enable_q <= power_enable_word_q[`PE_CONTROL_RX_BIT]
            & power_enable_word_q[`PE_CLOCK_BIT];
         dual_tone_enable_q <= power_enable_word_q[`PE_DUAL_TONE_BIT]
            & power_enable_word_q[`PE_CLOCK_BIT];
         speech_tx_rx_enable_q <= power_enable_word_q[`PE_SPEECH_BIT]
            & power_enable_word_q[`PE_CLOCK_BIT];
         power_mode_q <= decode_mode(power_enable_word_q[`PE_MODE_MSB:0]);
      end
   end

   // Forward-channel options, passed on as named levels.
   always @(posedge clk) begin
      if (rst) begin
         two_busy_bits_q <= 1'b0;
         five_repeat_limit_q <= 1'b0;
         auto_mute_enable_q <= 1'b0;
         rx_idle_enable_q <= 1'b0;
      end else begin
         two_busy_bits_q <= optional_control_word_q[`OC_BUSY_IDLE_BIT];
         five_repeat_limit_q <= optional_control_word_q[`OC_REPEAT_LIMIT_BIT];
         auto_mute_enable_q <= ~optional_control_word_q[`OC_AUTO_MUTE_OFF_BIT];
         rx_idle_enable_q <= optional_control_word_q[`OC_RX_IDLE_BIT];
      end
   end

   assign commence_write = addr_hit(write_valid_q, write_addr_q, `ADDR_TX_COMMENCE_STROBE);

   // Precursor sequencer. A commence write during a running precursor restarts it.
   always @* begin
      tx_state_d = tx_state_q;
      case (tx_state_q)
         TX_IDLE: begin
            if (commence_write) begin
               tx_state_d = TX_PRECURSOR;
            end
         end
         TX_PRECURSOR: begin
            if (commence_write) begin
               tx_state_d = TX_PRECURSOR;
            end else if (precursor_count_q == PRECURSOR_LAST) begin
               tx_state_d = TX_TAKE;
            end
         end
         TX_TAKE: begin
            tx_state_d = commence_write ? TX_PRECURSOR : TX_IDLE;
         end
         default: begin
            tx_state_d = TX_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         tx_state_q <= TX_IDLE;
         precursor_count_q <= {`PRECURSOR_COUNT_WIDTH{1'b0}};
         precursor_active_q <= 1'b0;
         buffer_take_q <= 1'b0;
         late_data_write_q <= 1'b0;
      end else begin
         tx_state_q <= tx_state_d;
         if (commence_write || tx_state_q != TX_PRECURSOR) begin
            precursor_count_q <= {`PRECURSOR_COUNT_WIDTH{1'b0}};
         end else begin
            precursor_count_q <= precursor_count_q + 16'd1;
         end
         precursor_active_q <= (tx_state_d == TX_PRECURSOR);
         buffer_take_q <= (tx_state_d == TX_TAKE);
         // A data load landing in the final two precursor cycles may be missed.
         late_data_write_q <= tx_data_word_write && tx_state_q == TX_PRECURSOR
            && !commence_write
            && (PRECURSOR_LAST - precursor_count_q) < `TX_DATA_MARGIN_CYCLES;
      end
   end

   // Sticky event flags; a set in the same cycle as its clear wins.
   assign event_set = event_pulse
      | ({{(`EVENT_MSB){1'b0}}, buffer_take_q} << `EV_TX_BUFFER_AVAILABLE);
   assign irq_mask_all = {irq_mask_two_q, irq_mask_one_q};

   always @(posedge clk) begin
      if (rst) begin
         event_flags_q <= {(`EVENT_MSB+1){1'b0}};
         interrupt_pin_q <= 1'b0;
      end else begin
         event_flags_q <= event_set | (event_flags_q & ~flag_clear);
         interrupt_pin_q <= (|(event_flags_q & irq_mask_all))
            ^ polarity_word_q[`POL_INTERRUPT_BIT];
      end
   end

endmodule

`default_nettype wire

/* hdl/power_mode_defines.vh */
`ifndef POWER_MODE_DEFINES_VH
`define POWER_MODE_DEFINES_VH

// Write addresses of the control words.
`define ADDR_POLARITY_WORD 8'h02
`define ADDR_POWER_ENABLE_WORD 8'h03
`define ADDR_OPTIONAL_CONTROL_WORD 8'h04
`define ADDR_IRQ_MASK_ONE 8'h05
`define ADDR_IRQ_MASK_TWO 8'h06
`define ADDR_TX_COMMENCE_STROBE 8'h08

// Reset values.
`define POWER_ENABLE_RESET 8'h01
`define OPTIONAL_CONTROL_RESET 4'h0
`define IRQ_MASK_ONE_RESET 7'h00
`define IRQ_MASK_TWO_RESET 8'h00
`define POLARITY_RESET 4'h0

// Field widths and positions.
`define POWER_ENABLE_WIDTH 8
`define OPTIONAL_CONTROL_WIDTH 4
`define IRQ_MASK_ONE_WIDTH 7
`define IRQ_MASK_TWO_WIDTH 8
`define POLARITY_WIDTH 4
`define EVENT_COUNT 15
`define PE_CLOCK_BIT 0
`define PE_SECURITY_BIT 1
`define PE_CONTROL_RX_BIT 2
`define PE_DUAL_TONE_BIT 3
`define PE_SPEECH_BIT 4
`define PE_MODE_MSB 4
`define OC_BUSY_IDLE_BIT 0
`define OC_REPEAT_LIMIT_BIT 1
`define OC_AUTO_MUTE_OFF_BIT 2
`define OC_RX_IDLE_BIT 3
`define POL_INTERRUPT_BIT 3
`define EV_TX_BUFFER_AVAILABLE 1
`define MASK_TWO_LSB 7
`define EVENT_MSB 14

// Legal power-mode encodings of bits 4 down to 0.
`define MODE_CODE_POWER_DOWN 5'h02
`define MODE_CODE_SHUTDOWN 5'h01
`define MODE_CODE_IDLE 5'h05
`define MODE_CODE_TONE 5'h09
`define MODE_CODE_FULL_TONE_OFF 5'h15
`define MODE_CODE_FULL_TONE_ON 5'h1d
`define MODE_WIDTH 7

// Serial write frame: eight address bits then eight data bits.
`define FRAME_BITS 5'd16
`define FRAME_COUNT_WIDTH 5
`define ADDR_WIDTH 8
`define DATA_WIDTH 8

// Precursor length and the margin for late transmit data loads.
`define PRECURSOR_CYCLES_DEFAULT 4800
`define PRECURSOR_COUNT_WIDTH 16
`define TX_DATA_MARGIN_CYCLES 16'd2
`define SYNC_WIDTH 3

`endif

/* hdl/pin_synchronizer.v */
`timescale 1ns/1ps
`default_nettype none

module pin_synchronizer #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst,
   input wire [WIDTH-1:0] pin_async,
   input wire [WIDTH-1:0] reset_level,
   output reg [WIDTH-1:0] pin_sync_q
);

   reg [WIDTH-1:0] stage_one_q;

   // Each pin gets its own two-stage chain; only the second stage is ever read.
   // Reset loads each pin's idle level, so no false edge or select follows reset.
   always @(posedge clk) begin
      if (rst) begin
         stage_one_q <= reset_level;
         pin_sync_q <= reset_level;
      end else begin
         stage_one_q <= pin_async;
         pin_sync_q <= stage_one_q;
      end
   end

endmodule

`default_nettype wire

/* test/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
   input wire logic clk,
   output logic spi_clk,
   output logic spi_select_n,
   output logic spi_data_in
);
   initial begin
      spi_clk = 1'b0;
      spi_select_n = 1'b1;
      spi_data_in = 1'b0;
   end

   // Sends nbits of a 16-bit frame, MSB first; fewer than 16 makes a cut-short frame.
   task automatic send(input logic [7:0] addr, input logic [7:0] data, input int nbits);
      logic [15:0] frame;
      frame = {addr, data};
      @(negedge clk);
      spi_select_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         spi_data_in = frame[i];
         repeat (4) @(negedge clk);
         spi_clk = 1'b1;
         repeat (4) @(negedge clk);
         spi_clk = 1'b0;
      end
      spi_select_n = 1'b1;
      // A released data line must not keep looking valid.
      spi_data_in = ~spi_data_in;
   endtask
endmodule

`default_nettype wire

/* test/power_mode_irq_mask_control_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_irq_mask_control_chk #(
   parameter PRECURSOR_CYCLES = 4800
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [14:0] event_pulse,
   input wire logic [14:0] flag_clear,
   input wire logic tx_data_word_write,
   input wire logic [14:0] event_flags_q,
   input wire logic clock_power_q,
   input wire logic processor_power_q,
   input wire logic keypad_power_q,
   input wire logic control_rx_enable_q,
   input wire logic dual_tone_enable_q,
   input wire logic speech_tx_rx_enable_q,
   input wire logic [6:0] power_mode_q,
   input wire logic auto_mute_enable_q,
   input wire logic precursor_active_q,
   input wire logic buffer_take_q,
   input wire logic late_data_write_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic [15:0] pre_cnt_q;
   always @(posedge clk) begin
      if (rst || !precursor_active_q) pre_cnt_q <= 16'h0000;
      else pre_cnt_q <= pre_cnt_q + 16'h0001;
   end

   property p_reset_state;
      $fell(rst) |-> ##2 (clock_power_q && keypad_power_q && power_mode_q == 7'h02 && auto_mute_enable_q);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_keypad;
      !$past(rst) |-> keypad_power_q;
   endproperty
   a_keypad: assert property (p_keypad) else $error("keypad power dropped");
   property p_off_gates;
      processor_power_q == clock_power_q
         && (clock_power_q || !(control_rx_enable_q || dual_tone_enable_q || speech_tx_rx_enable_q));
   endproperty
   a_off_gates: assert property (p_off_gates) else $error("section powered without clock");
   property p_mode_onehot;
      $onehot(power_mode_q);
   endproperty
   a_mode_onehot: assert property (p_mode_onehot) else $error("power mode not one-hot");
   property p_mode_full;
      power_mode_q[5] |-> clock_power_q && control_rx_enable_q && dual_tone_enable_q && speech_tx_rx_enable_q;
   endproperty
   a_mode_full: assert property (p_mode_full) else $error("full mode with section off");
   property p_mode_down;
      power_mode_q[0] |-> !clock_power_q;
   endproperty
   a_mode_down: assert property (p_mode_down) else $error("power-down with clock on");
   property p_precursor_len;
      buffer_take_q |-> pre_cnt_q == PRECURSOR_CYCLES && !precursor_active_q && $past(precursor_active_q);
   endproperty
   a_precursor_len: assert property (p_precursor_len) else $error("precursor length wrong");
   property p_take_flag;
      buffer_take_q |=> event_flags_q[1];
   endproperty
   a_take_flag: assert property (p_take_flag) else $error("buffer available not flagged");
   property p_flag_set;
      |event_pulse |=> (event_flags_q & $past(event_pulse)) == $past(event_pulse);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("event flag not set");
   // The buffer-available set comes from the take pulse and beats a clear like any other set.
   property p_flag_clear;
      |(flag_clear & ~event_pulse) |=> (event_flags_q & $past(flag_clear) & ~$past(event_pulse)
         & ~{13'h0000, $past(buffer_take_q), 1'b0}) == 15'h0000;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("event flag not cleared");
   property p_late_write;
      late_data_write_q |-> $past(tx_data_word_write) && $past(precursor_active_q);
   endproperty
   a_late_write: assert property (p_late_write) else $error("late write flagged wrongly");
endmodule

bind power_mode_irq_mask_control power_mode_irq_mask_control_chk #(.PRECURSOR_CYCLES(PRECURSOR_CYCLES)) chk_u (
   .clk(clk), .rst(rst), .event_pulse(event_pulse), .flag_clear(flag_clear),
   .tx_data_word_write(tx_data_word_write), .event_flags_q(event_flags_q), .clock_power_q(clock_power_q),
   .processor_power_q(processor_power_q), .keypad_power_q(keypad_power_q),
   .control_rx_enable_q(control_rx_enable_q), .dual_tone_enable_q(dual_tone_enable_q),
   .speech_tx_rx_enable_q(speech_tx_rx_enable_q), .power_mode_q(power_mode_q),
   .auto_mute_enable_q(auto_mute_enable_q), .precursor_active_q(precursor_active_q),
   .buffer_take_q(buffer_take_q), .late_data_write_q(late_data_write_q));

`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clk = 1'b0;
   logic rst, spi_clk, spi_select_n, spi_data_in, tx_data_word_write;
   logic [14:0] event_pulse, flag_clear, event_flags_q;
   logic interrupt_pin_q, clock_power_q, processor_power_q, keypad_power_q, control_rx_enable_q;
   logic dual_tone_enable_q, speech_tx_rx_enable_q, two_busy_bits_q, five_repeat_limit_q;
   logic auto_mute_enable_q, rx_idle_enable_q, precursor_active_q, buffer_take_q, late_data_write_q;
   logic [6:0] power_mode_q;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int act_n = 0;
   // The six legal codes, one forbidden code that must decode as illegal, then shutdown with unused bits set.
   localparam logic [7:0] MODE_CODES [8] = '{8'h02, 8'h01, 8'h05, 8'h09, 8'h15, 8'h1d, 8'h03, 8'he1};

   always #5 clk = ~clk;

   spi_host_model spi_u (.clk(clk), .spi_clk(spi_clk), .spi_select_n(spi_select_n), .spi_data_in(spi_data_in));

   power_mode_irq_mask_control #(.PRECURSOR_CYCLES(8)) dut_u (
      .clk(clk), .rst(rst), .spi_clk(spi_clk), .spi_select_n(spi_select_n), .spi_data_in(spi_data_in),
      .event_pulse(event_pulse), .flag_clear(flag_clear), .tx_data_word_write(tx_data_word_write),
      .event_flags_q(event_flags_q), .interrupt_pin_q(interrupt_pin_q), .clock_power_q(clock_power_q),
      .processor_power_q(processor_power_q), .keypad_power_q(keypad_power_q),
      .control_rx_enable_q(control_rx_enable_q), .dual_tone_enable_q(dual_tone_enable_q),
      .speech_tx_rx_enable_q(speech_tx_rx_enable_q), .power_mode_q(power_mode_q),
      .two_busy_bits_q(two_busy_bits_q), .five_repeat_limit_q(five_repeat_limit_q),
      .auto_mute_enable_q(auto_mute_enable_q), .rx_idle_enable_q(rx_idle_enable_q),
      .precursor_active_q(precursor_active_q), .buffer_take_q(buffer_take_q),
      .late_data_write_q(late_data_write_q));

   always @(negedge clk) act_n <= precursor_active_q ? act_n + 1 : 0;

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic spi_write(input logic [7:0] addr, input logic [7:0] data);
      spi_u.send(addr, data, 16);
      repeat (6) @(negedge clk);
   endtask

   task automatic strobe(input logic is_clear, input logic [14:0] v);
      if (is_clear) flag_clear = v;
      else event_pulse = v;
      @(negedge clk);
      flag_clear = 15'h0000;
      event_pulse = 15'h0000;
      @(negedge clk);
   endtask

   task automatic t_reset();
      check("reset_outputs", 16'h1c10, {clock_power_q, processor_power_q, keypad_power_q, control_rx_enable_q,
         dual_tone_enable_q, speech_tx_rx_enable_q, two_busy_bits_q, five_repeat_limit_q, auto_mute_enable_q,
         rx_idle_enable_q, precursor_active_q, buffer_take_q, late_data_write_q});
      check("reset_mode", 16'h0002, power_mode_q);
      check("reset_irq", 16'h0000, {event_flags_q, interrupt_pin_q});
      $display("test t_reset done");
   endtask

   task automatic t_modes();
      logic [7:0] c;
      for (int i = 0; i < 8; i++) begin
         c = MODE_CODES[i];
         spi_write(8'h03, c);
         check("mode", (i < 6) ? (16'h0001 << i) : (i == 6) ? 16'h0040 : 16'h0002, power_mode_q);
         check("enables", {c[0], c[2] & c[0], c[3] & c[0], c[4] & c[0]},
            {clock_power_q, control_rx_enable_q, dual_tone_enable_q, speech_tx_rx_enable_q});
      end
      $display("test t_modes done");
   endtask

   task automatic t_options();
      logic [7:0] v [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hf0};
      for (int i = 0; i < 5; i++) begin
         spi_write(8'h04, v[i]);
         check("options", v[i][3:0], {rx_idle_enable_q, ~auto_mute_enable_q, five_repeat_limit_q,
            two_busy_bits_q});
      end
      $display("test t_options done");
   endtask

   task automatic t_refuse();
      spi_u.send(8'h03, 8'h1d, 12);
      spi_write(8'h07, 8'h1d);
      check("cut_frame_mode", 16'h0002, power_mode_q);
      $display("test t_refuse done");
   endtask

   task automatic t_irq();
      spi_write(8'h05, 8'h40);
      spi_write(8'h06, 8'h80);
      strobe(1'b0, 15'h0041);
      check("irq_tone", 16'h0001, interrupt_pin_q);
      strobe(1'b1, 15'h0040);
      check("irq_masked_out", 16'h0000, interrupt_pin_q);
      check("flags_left", 16'h0001, event_flags_q);
      strobe(1'b1, 15'h0001);
      strobe(1'b0, 15'h4000);
      check("irq_mask_two", 16'h0001, interrupt_pin_q);
      spi_write(8'h02, 8'h08);
      check("irq_low_active", 16'h0000, interrupt_pin_q);
      strobe(1'b1, 15'h4000);
      check("irq_low_idle", 16'h0001, interrupt_pin_q);
      spi_write(8'h02, 8'h00);
      check("irq_high_idle", 16'h0000, interrupt_pin_q);
      $display("test t_irq done");
   endtask

   task automatic t_commence();
      int w;
      logic late;
      w = 0;
      late = 1'b0;
      spi_write(8'h05, 8'h02);
      spi_u.send(8'h08, 8'h5a, 16);
      while (buffer_take_q !== 1'b1 && w < 200) begin
         @(negedge clk);
         tx_data_word_write = (act_n == 7) && precursor_active_q;
         if (late_data_write_q === 1'b1) late = 1'b1;
         w++;
      end
      check("precursor_len", 16'h0008, act_n[15:0]);
      check("take_ends_precursor", 16'h0000, precursor_active_q);
      check("late_write", 16'h0001, late);
      @(negedge clk);
      check("buffer_flag", 16'h0002, event_flags_q);
      @(negedge clk);
      check("buffer_irq", 16'h0001, interrupt_pin_q);
      strobe(1'b1, 15'h0002);
      $display("test t_commence done");
   endtask

   initial begin
      rst = 1'b1;
      event_pulse = 15'h0000;
      flag_clear = 15'h0000;
      tx_data_word_write = 1'b0;
      // Four rising edges fall inside reset before it is released on a falling edge.
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_modes();
      t_options();
      t_refuse();
      t_irq();
      t_commence();
      summarize();
   end
endmodule

`default_nettype wire
